// ===== common/vidm_pkg.sv
// Purpose: Shared constants and types for the voltage code monitor block
// Assumes: 8-bit register port, 125 MHz clock
// Notes:   Offsets are the printed register addresses
package vidm_pkg;
  localparam logic [7:0] ADDR_ISR2  = 8'h42;
  localparam logic [7:0] ADDR_CODE  = 8'h43;
  localparam logic [7:0] ADDR_IMR2  = 8'h75;
  localparam logic [7:0] ADDR_CFG5  = 8'h7C;
  localparam logic [7:0] ADDR_IRQS  = 8'hF0;
  localparam logic [7:0] ADDR_IRQM  = 8'hF1;
  localparam int CODE_W      = 5;
  localparam int BIT_CODE5   = 5;
  localparam int BIT_THRESH  = 6;
  localparam int BIT_ROLE    = 7;
  localparam int BIT_GPEN    = 4;
  localparam int BIT_G6_LO   = 2;
  localparam int BIT_G6_HI   = 3;
  localparam int BIT_FLAG    = 0;
  localparam int WINDOW_NS   = 11000;
  localparam int CLK_PER_NS  = 8;
  localparam int WINDOW_CYC  = WINDOW_NS / CLK_PER_NS;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] G6_OUT   = 2'b01;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } vidm_bus_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } vidm_state_e;
endpackage

// ===== design/vidm_top.sv
// Purpose: Voltage code monitor with change detect and general-purpose outputs
// Assumes: Pins synchronous to clk; register port with read data one cycle later
// Notes:   Analog threshold is only exported as a control level
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module vidm_top #(
  parameter int WIN_CYC = vidm_pkg::WINDOW_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata,
  input  wire logic [4:0]               code_in,
  input  wire logic                     shared_in,
  input  wire logic                     supply_out_of_limit,
  input  wire logic                     gp6_in,
  output logic      [4:0]               code_out,
  output logic      [4:0]               code_oe,
  output logic                          shared_out,
  output logic                          shared_oe,
  output logic                          gp6_out,
  output logic                          gp6_oe,
  output logic                          input_threshold_select,
  output logic                          alert,
  output logic                          irq
);
  vidm_pkg::vidm_bus_s bus;
  logic [7:0]  code_q;
  logic [7:0]  imr2_q;
  logic [7:0]  cfg5_q;
  logic [7:0]  irqs_q;
  logic [7:0]  irqm_q;
  logic        chg_q;
  logic [5:0]  ref_q;
  logic [15:0] cnt_q;
  logic [7:0]  rdata_q;
  logic [4:0]  code_out_q;
  logic [4:0]  code_oe_q;
  logic        sh_out_q;
  logic        sh_oe_q;
  logic        g6_out_q;
  logic        g6_oe_q;
  logic        thr_sel_q;
  logic        alert_q;
  logic        irq_q;
  vidm_pkg::vidm_state_e st_q;
  vidm_pkg::vidm_state_e st_d;

  assign bus.addr  = reg_addr;
  assign bus.wdata = reg_wdata;
  assign bus.wr    = reg_wr;
  assign bus.rd    = reg_rd;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  wire       role_code  = code_q[vidm_pkg::BIT_ROLE];
  wire       gp_mode    = cfg5_q[vidm_pkg::BIT_GPEN];
  wire [5:0] levels     = {role_code ? shared_in : 1'b0, code_in};
  wire       win_end    = (cnt_q == 16'(WIN_CYC - 1));
  // Compare live levels to the snapshot taken one window earlier
  wire       detect_on  = role_code && !gp_mode;
  wire       code_event = detect_on && win_end && (levels != ref_q);
  wire       rd_isr2    = bus.rd && hit(bus.addr, vidm_pkg::ADDR_ISR2);
  wire       flag_bit   = role_code ? chg_q : supply_out_of_limit;
  wire       alert_d    = chg_q && role_code && !imr2_q[vidm_pkg::BIT_FLAG];
  wire [7:0] ev_vec     = {7'h00, code_event};
  wire [7:0] irqs_d     = (irqs_q & ~((bus.wr && hit(bus.addr, vidm_pkg::ADDR_IRQS))
                          ? bus.wdata : 8'h00)) | ev_vec;
  // Read mux; bit 5 masked in supply role
  wire [7:0] code_view  = {code_q[7:6], levels};
  wire [7:0] rd_mux     = hit(bus.addr, vidm_pkg::ADDR_ISR2) ? {7'h00, flag_bit} :
                          hit(bus.addr, vidm_pkg::ADDR_CODE) ? code_view :
                          hit(bus.addr, vidm_pkg::ADDR_IMR2) ? imr2_q :
                          hit(bus.addr, vidm_pkg::ADDR_CFG5) ? cfg5_q :
                          hit(bus.addr, vidm_pkg::ADDR_IRQS) ? irqs_q :
                          hit(bus.addr, vidm_pkg::ADDR_IRQM) ? irqm_q : 8'h00;

  always_comb
  begin
    case (st_q)
      vidm_pkg::ST_IDLE: st_d = detect_on ? vidm_pkg::ST_RUN : vidm_pkg::ST_IDLE;
      vidm_pkg::ST_RUN:  st_d = detect_on ? vidm_pkg::ST_RUN : vidm_pkg::ST_IDLE;
      default:           st_d = vidm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_q  <= vidm_pkg::ST_IDLE;
      cnt_q <= 16'h0000;
      ref_q <= 6'h00;
    end
    else
    begin
      st_q <= st_d;
      // Restart window on entry so the first snapshot is fresh
      if (st_q != vidm_pkg::ST_RUN || win_end)
      begin
        cnt_q <= 16'h0000;
        ref_q <= levels;
      end
      else
        cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      chg_q <= 1'b0;
    else if (code_event)
      chg_q <= 1'b1;
    else if (rd_isr2)
      chg_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      code_q <= vidm_pkg::RST_BYTE;
      imr2_q <= vidm_pkg::RST_BYTE;
      cfg5_q <= vidm_pkg::RST_BYTE;
      irqm_q <= vidm_pkg::RST_BYTE;
      irqs_q <= vidm_pkg::RST_BYTE;
    end
    else
    begin
      if (bus.wr && hit(bus.addr, vidm_pkg::ADDR_CODE))
        code_q <= bus.wdata;
      if (bus.wr && hit(bus.addr, vidm_pkg::ADDR_IMR2))
        imr2_q <= bus.wdata;
      if (bus.wr && hit(bus.addr, vidm_pkg::ADDR_CFG5))
        cfg5_q <= bus.wdata;
      if (bus.wr && hit(bus.addr, vidm_pkg::ADDR_IRQM))
        irqm_q <= bus.wdata;
      irqs_q <= irqs_d;
    end
  end

  // Pin drivers: general pins 0..4, shared pin, and pin six
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      code_out_q <= 5'h00;
      code_oe_q  <= 5'h00;
      sh_out_q   <= 1'b0;
      sh_oe_q    <= 1'b0;
      g6_out_q   <= 1'b0;
      g6_oe_q    <= 1'b0;
      thr_sel_q  <= 1'b0;
      alert_q    <= 1'b0;
      irq_q      <= 1'b0;
      rdata_q    <= 8'h00;
    end
    else
    begin
      code_out_q <= code_q[vidm_pkg::CODE_W-1:0];
      code_oe_q  <= {vidm_pkg::CODE_W{gp_mode}};
      sh_out_q   <= code_q[vidm_pkg::BIT_CODE5];
      sh_oe_q    <= gp_mode && role_code;
      g6_out_q   <= code_q[vidm_pkg::BIT_THRESH];
      g6_oe_q    <= cfg5_q[vidm_pkg::BIT_G6_HI:vidm_pkg::BIT_G6_LO] == vidm_pkg::G6_OUT;
      thr_sel_q  <= code_q[vidm_pkg::BIT_THRESH];
      alert_q    <= alert_d;
      irq_q      <= |(irqs_q & irqm_q);
      rdata_q    <= bus.rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata              = rdata_q;
  assign code_out               = code_out_q;
  assign code_oe                = code_oe_q;
  assign shared_out             = sh_out_q;
  assign shared_oe              = sh_oe_q;
  assign gp6_out                = g6_out_q;
  assign gp6_oe                 = g6_oe_q;
  assign input_threshold_select = thr_sel_q;
  assign alert                  = alert_q;
  assign irq                    = irq_q;

  wire unused_gp6 = gp6_in;

  AST_BIT5_ZERO: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == vidm_pkg::ADDR_CODE && !code_q[vidm_pkg::BIT_ROLE])
    |=> reg_rdata[vidm_pkg::BIT_CODE5] == 1'b0) else $error("bit5 not zero");
  AST_LOW_BITS: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == vidm_pkg::ADDR_CODE) |=> reg_rdata[4:0] == $past(code_in))
    else $error("code bits mismatch");
  AST_ROLE_RB: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == vidm_pkg::ADDR_CODE) |=> reg_rdata[7] == $past(code_q[7]))
    else $error("role readback");
  AST_INPUT_THRESHOLD_SELECT: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == vidm_pkg::ADDR_CODE) |=> ##1 input_threshold_select == $past(reg_wdata[6], 2))
    else $error("threshold not applied");
  AST_SUPPLY: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == vidm_pkg::ADDR_ISR2 && !code_q[7])
    |=> reg_rdata[0] == $past(supply_out_of_limit)) else $error("supply flag");
  AST_NO_DET: assert property (@(posedge clk) disable iff (reset)
    !detect_on |-> !code_event) else $error("detect while off");
  AST_STICKY: assert property (@(posedge clk) disable iff (reset)
    (chg_q && !rd_isr2) |=> chg_q) else $error("flag lost");
  AST_ALERT: assert property (@(posedge clk) disable iff (reset)
    (chg_q && code_q[7] && imr2_q[0]) |=> !alert) else $error("masked alert");
  AST_SET: assert property (@(posedge clk) disable iff (reset)
    code_event |=> chg_q ##1 (alert || imr2_q[0] || !code_q[7]))
    else $error("change not flagged");
  AST_GPOE: assert property (@(posedge clk) disable iff (reset)
    $rose(gp_mode) |=> code_oe == 5'h1F) else $error("gp outputs off");

  // Change detect in two steps: window verdict, then sticky flag
  sequence s_change_seen;
    detect_on && win_end && (levels != ref_q);
  endsequence

  sequence s_flag_up;
    chg_q;
  endsequence

  AST_CHANGE_SETS: assert property (@(posedge clk) disable iff (reset)
    s_change_seen
    |=> s_flag_up)
    else $error("change window missed");

  AST_QUIET_CLEAR: assert property (@(posedge clk) disable iff (reset)
    (!chg_q && !code_event)
    |=> !chg_q)
    else $error("flag set without change");

  AST_READ_CLEARS: assert property (@(posedge clk) disable iff (reset)
    (rd_isr2 && !code_event)
    |=> !chg_q)
    else $error("flag kept after read");

  AST_SHARED_LEVEL: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == vidm_pkg::ADDR_CODE && role_code)
    |=> reg_rdata[vidm_pkg::BIT_CODE5] == $past(shared_in))
    else $error("shared level not shown");

  AST_FLAG_CODE_ROLE: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == vidm_pkg::ADDR_ISR2 && role_code)
    |=> reg_rdata[vidm_pkg::BIT_FLAG] == $past(chg_q))
    else $error("change flag not shown");

  AST_GP_POLARITY: assert property (@(posedge clk) disable iff (reset)
    gp_mode
    |=> code_out == $past(code_q[vidm_pkg::CODE_W-1:0]))
    else $error("gp polarity wrong");

  AST_GP_RELEASED: assert property (@(posedge clk) disable iff (reset)
    !gp_mode
    |=> code_oe == 5'h00)
    else $error("code pins driven");

  AST_SHARED_DRIVE: assert property (@(posedge clk) disable iff (reset)
    (gp_mode && role_code)
    |=> shared_oe)
    else $error("shared pin not driven");

  AST_SHARED_FLOAT: assert property (@(posedge clk) disable iff (reset)
    !(gp_mode && role_code)
    |=> !shared_oe)
    else $error("shared pin driven");

  AST_PIN6_OUT: assert property (@(posedge clk) disable iff (reset)
    (cfg5_q[vidm_pkg::BIT_G6_HI:vidm_pkg::BIT_G6_LO] == vidm_pkg::G6_OUT)
    |=> gp6_oe)
    else $error("pin six not output");

  AST_PIN6_IN: assert property (@(posedge clk) disable iff (reset)
    (cfg5_q[vidm_pkg::BIT_G6_HI:vidm_pkg::BIT_G6_LO] != vidm_pkg::G6_OUT)
    |=> !gp6_oe)
    else $error("pin six not input");

  AST_PIN6_VALUE: assert property (@(posedge clk) disable iff (reset)
    (cfg5_q[vidm_pkg::BIT_G6_HI:vidm_pkg::BIT_G6_LO] == vidm_pkg::G6_OUT)
    |=> gp6_out == $past(code_q[vidm_pkg::BIT_THRESH]))
    else $error("pin six value wrong");

  AST_ALERT_RAISE: assert property (@(posedge clk) disable iff (reset)
    (chg_q && role_code && !imr2_q[vidm_pkg::BIT_FLAG])
    |=> alert)
    else $error("alert missing");

  AST_ALERT_IDLE: assert property (@(posedge clk) disable iff (reset)
    !chg_q
    |=> !alert)
    else $error("alert without change");

  AST_WINDOW_BOUND: assert property (@(posedge clk) disable iff (reset)
    cnt_q < 16'(WIN_CYC))
    else $error("window counter overran");

  AST_IDLE_NO_COUNT: assert property (@(posedge clk) disable iff (reset)
    (st_q == vidm_pkg::ST_IDLE)
    |=> cnt_q == 16'h0000)
    else $error("window runs while off");

  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (reset)
    (|(irqs_q & irqm_q))
    |=> irq)
    else $error("irq missing");

  AST_THR_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
    1'b1
    |=> input_threshold_select == $past(code_q[vidm_pkg::BIT_THRESH]))
    else $error("threshold select lags");
endmodule // vidm_top

// ===== sim/vidm_code_src.sv
// Purpose: Code line source standing in for the processor side
// Assumes: Requested levels change only right after rising clock edges
// Notes:   A line the block enables follows the block; no contention model
`timescale 1ns/1ps
module vidm_code_src (
  input  wire logic [4:0] code_req,
  input  wire logic       shared_req,
  input  wire logic [4:0] code_out,
  input  wire logic [4:0] code_oe,
  input  wire logic       shared_out,
  input  wire logic       shared_oe,
  output logic      [4:0] code_in,
  output logic            shared_in
);
  // Wire level resolved per pin from the enables
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      code_in[i] = code_oe[i] ? code_out[i] : code_req[i];
    end
    shared_in = shared_oe ? shared_out : shared_req;
  end
endmodule // vidm_code_src

// ===== sim/vidm_top_test.sv
// Purpose: Register level test of the voltage code monitor
// Assumes: Short window parameter so change detection fits a quick run
// Notes:   Waits of several windows plus a few cycles; detection latency is up to one window
`timescale 1ns/1ps
module vidm_top_test;
  localparam int W = 8;
  logic       clk, reset, reg_wr, reg_rd, sol, shared_req, shared_in, shared_out, shared_oe;
  logic       gp6_out, gp6_oe, thr_sel, alert, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [4:0] code_req, code_in, code_out, code_oe;
  logic [7:0] rst_addr [6] = '{8'h42, 8'h75, 8'h7C, 8'hF0, 8'hF1, 8'h10};
  int         n_errors = 0;
  int         checks_done = 0;
  vidm_top #(.WIN_CYC(W)) dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .code_in(code_in), .shared_in(shared_in), .supply_out_of_limit(sol), .gp6_in(1'b0),
    .code_out(code_out), .code_oe(code_oe), .shared_out(shared_out), .shared_oe(shared_oe),
    .gp6_out(gp6_out), .gp6_oe(gp6_oe), .input_threshold_select(thr_sel), .alert(alert),
    .irq(irq));
  vidm_code_src src (.code_req(code_req), .shared_req(shared_req), .code_out(code_out),
    .code_oe(code_oe), .shared_out(shared_out), .shared_oe(shared_oe), .code_in(code_in),
    .shared_in(shared_in));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic print_verdict();
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data live only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    chk(nm, exp, rd_val);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  initial
  begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    sol = 1'b0;
    shared_req = 1'b1;
    code_req = 5'h15;
    idle(16);
    reset <= 1'b0;
    idle(2);
    foreach (rst_addr[i]) rchk("reset value", rst_addr[i], 8'h00);
    rchk("code reg", 8'h43, 8'h15);
    sol <= 1'b1;
    idle(2);
    rchk("supply flag", 8'h42, 8'h01);
    sol <= 1'b0;
    wr(8'h43, 8'hC0);
    rchk("role read", 8'h43, 8'hF5);
    chk("threshold", 8'h01, {7'h00, thr_sel});
    wr(8'hF1, 8'h01);
    idle(4 * W);
    rchk("settle", 8'h42, 8'h00);
    wr(8'hF0, 8'h01);
    code_req <= 5'h0A;
    idle(3 * W + 4);
    chk("alert", 8'h01, {7'h00, alert});
    chk("irq", 8'h01, {7'h00, irq});
    rchk("change", 8'h42, 8'h01);
    rchk("change clear", 8'h42, 8'h00);
    chk("alert off", 8'h00, {7'h00, alert});
    rchk("irq status", 8'hF0, 8'h01);
    wr(8'hF0, 8'h01);
    idle(2);
    chk("irq off", 8'h00, {7'h00, irq});
    wr(8'hF1, 8'h00);
    wr(8'h75, 8'h01);
    code_req <= 5'h1F;
    idle(3 * W + 4);
    chk("masked alert", 8'h00, {7'h00, alert});
    chk("masked irq", 8'h00, {7'h00, irq});
    rchk("masked change", 8'h42, 8'h01);
    wr(8'h43, 8'h00);
    wr(8'hF0, 8'h01);
    code_req <= 5'h00;
    idle(3 * W + 4);
    rchk("no detect", 8'hF0, 8'h00);
    rchk("supply role", 8'h42, 8'h00);
    wr(8'h43, 8'hCA);
    wr(8'h7C, 8'h14);
    idle(2);
    chk("gp value", 8'h0A, {3'h0, code_out});
    chk("gp enable", 8'h1F, {3'h0, code_oe});
    chk("gp shared", 8'h06, {5'h00, shared_oe, gp6_oe, shared_out});
    chk("pin six", 8'h01, {7'h00, gp6_out});
    rchk("gp pins", 8'h43, 8'hCA);
    wr(8'h7C, 8'h18);
    idle(2);
    chk("pin six in", 8'h00, {7'h00, gp6_oe});
    print_verdict();
  end
endmodule // vidm_top_test
